// ### rtl/ivpm_map.v
/*
  Vectored interrupt source map: gathers peripheral and pin request
  pulses into pending flags, selects the lowest pending index and hands
  its vector address to the core on acknowledge.
  Assumes request inputs are synchronous one-cycle or level pulses and
  that masking and priority groups are handled outside.
  Assumes the core holds its acknowledge only while it wants a vector;
  a held acknowledge drains one flag per enabled edge.
  Assumes clk_en_in is common to every source, so a frozen map misses
  nothing that a frozen peripheral would have raised.
*/
`timescale 1ns/100ps
`include "ivpm_regs.vh"

// Notes on behaviour
// - 24 sources small, 25 largest package.
// - Pins 0-5 at 1-6, pin 6 at 22.
// - Serial B receive error at index 7.
// - Serial B receive done at index 8.
// - Serial B transmit done at index 9.
// - Clocked serial and serial A tx share 10.
// - Timer H one match at index 11.
// - Timer H zero match at index 12.
// - Event counter A match at index 13.
// - Wide timer channel A at index 14.
// - Wide timer channel B at index 15.
// - Conversion done at index 16.
// - Serial A rx done or error share 17.
// - Watch interval 18, watch overflow 21.
// - Event counter B match at index 19.
// - Simultaneous requests served lowest index first.
// - Two-wire or muldiv done share 23.
module ivpm_map #(
  parameter LARGE_PKG = 1'b1
) (
  // Clock, reset and the freeze control
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  // Supply monitor and external pin edges
  input wire low_voltage_irq_in,
  input wire [6:0] pin_edge_irq_in,
  // Second asynchronous serial channel
  input wire serial_b_rx_error_irq_in,
  input wire serial_b_rx_done_irq_in,
  input wire serial_b_tx_done_irq_in,
  // Clocked serial end and first channel transmit end, one shared flag
  input wire clocked_serial_done_irq_in,
  input wire serial_a_tx_done_irq_in,
  // Timer and counter matches
  input wire timer_h_one_match_irq_in,
  input wire timer_h_zero_match_irq_in,
  input wire event_counter_a_match_irq_in,
  input wire wide_timer_chan_a_irq_in,
  input wire wide_timer_chan_b_irq_in,
  // Converter, first channel receive and watch timer interval
  input wire conversion_done_irq_in,
  input wire serial_a_rx_irq_in,
  input wire watch_interval_irq_in,
  // Counter B, key inputs and watch timer overflow
  input wire event_counter_b_match_irq_in,
  input wire key_input_irq_in,
  input wire watch_overflow_irq_in,
  // Two-wire end and multiply/divide end, one shared flag
  input wire two_wire_done_irq_in,
  input wire muldiv_done_irq_in,
  // Core side of the vector handshake
  input wire ack_in,
  output wire irq_req_out,
  output reg [`IVPM_IDX_W-1:0] req_idx_ff_out,
  output reg [`IVPM_VEC_W-1:0] vec_addr_ff_out,
  output reg vec_valid_ff_out,
  output wire [`IVPM_IDX_W-1:0] src_count_out,
  output wire [`IVPM_NUM_SRC-1:0] pending_out
);

  reg [`IVPM_NUM_SRC-1:0] pend_ff;
  reg [`IVPM_NUM_SRC-1:0] raw_req;
  reg [`IVPM_NUM_SRC-1:0] clr_mask;
  reg [`IVPM_NUM_SRC-1:0] nxt_pend;
  wire pick_any;
  wire [`IVPM_IDX_W-1:0] pick_idx;
  wire [`IVPM_VEC_W-1:0] pick_vec;
  wire ack_take;
  wire [6:0] pin_hit;
  genvar g;

  // One gate per pin; only pin 6 depends on the package, since its pad
  // is missing on the smaller ones and a floating line must not count
  generate
    for (g = 0; g < 7; g = g + 1)
    begin : g_pin
      if (g == 6)
      begin : g_gated
        assign pin_hit[g] = pin_edge_irq_in[g] & LARGE_PKG;
      end
      else
      begin : g_plain
        assign pin_hit[g] = pin_edge_irq_in[g];
      end
    end
  endgenerate

  // Source count including the software break
  assign src_count_out = LARGE_PKG ? `IVPM_SRC_LARGE : `IVPM_SRC_SMALL;

  // Route each source line to its priority index
  always @*
  begin
    raw_req = {`IVPM_NUM_SRC{1'b0}};
    // Supply monitor takes the top slot
    raw_req[`IVPM_PRI_LOW_VOLTAGE] = low_voltage_irq_in;
    // Pins 0 to 5 sit on consecutive slots just below it
    raw_req[`IVPM_PRI_PIN0 + 0] = pin_hit[0];
    raw_req[`IVPM_PRI_PIN0 + 1] = pin_hit[1];
    raw_req[`IVPM_PRI_PIN0 + 2] = pin_hit[2];
    raw_req[`IVPM_PRI_PIN0 + 3] = pin_hit[3];
    raw_req[`IVPM_PRI_PIN0 + 4] = pin_hit[4];
    raw_req[`IVPM_PRI_PIN0 + 5] = pin_hit[5];
    // Pin 6 was added late and sits far down the order
    raw_req[`IVPM_PRI_PIN6] = pin_hit[6];
    // Second serial channel: error ahead of data so it is seen first
    raw_req[`IVPM_PRI_SERB_ERR] = serial_b_rx_error_irq_in;
    raw_req[`IVPM_PRI_SERB_RX] = serial_b_rx_done_irq_in;
    raw_req[`IVPM_PRI_SERB_TX] = serial_b_tx_done_irq_in;
    // Shared flag: the handler must poll both units to tell them apart
    raw_req[`IVPM_PRI_CSI_SERA_TX] = clocked_serial_done_irq_in
      | serial_a_tx_done_irq_in;
    // Timer and counter matches
    raw_req[`IVPM_PRI_TIMER_H_ONE] = timer_h_one_match_irq_in;
    raw_req[`IVPM_PRI_TIMER_H_ZERO] = timer_h_zero_match_irq_in;
    raw_req[`IVPM_PRI_EVA] = event_counter_a_match_irq_in;
    raw_req[`IVPM_PRI_WIDE_A] = wide_timer_chan_a_irq_in;
    raw_req[`IVPM_PRI_WIDE_B] = wide_timer_chan_b_irq_in;
    // Converter end
    raw_req[`IVPM_PRI_CONV] = conversion_done_irq_in;
    // First channel receive: done and error already merged upstream
    raw_req[`IVPM_PRI_SERA_RX] = serial_a_rx_irq_in;
    // Watch timer: interval and overflow are separate slots
    raw_req[`IVPM_PRI_WATCH_INT] = watch_interval_irq_in;
    raw_req[`IVPM_PRI_WATCH_OVF] = watch_overflow_irq_in;
    raw_req[`IVPM_PRI_EVB] = event_counter_b_match_irq_in;
    // Key inputs
    raw_req[`IVPM_PRI_KEY] = key_input_irq_in;
    // Shared last slot; the handler polls both units
    raw_req[`IVPM_PRI_TWO_WIRE] = two_wire_done_irq_in | muldiv_done_irq_in;
  end

  // An acknowledge only counts while something is on offer
  assign ack_take = ack_in & pick_any;

  // Picker works on pending flags only, so a new request waits one cycle
  ivpm_pick #(
    .N(`IVPM_NUM_SRC)
  ) u_pick (
    .req_in(pend_ff),
    .any_out(pick_any),
    .idx_out(pick_idx),
    .vec_out(pick_vec)
  );

  // Acknowledge clears the served flag; a fresh request in the same cycle wins
  always @*
  begin
    clr_mask = {`IVPM_NUM_SRC{1'b0}};
    if (ack_take)
    begin
      clr_mask[pick_idx] = 1'b1;
    end
    // Set after clear: an event in the acknowledge cycle is not lost
    nxt_pend = (pend_ff & ~clr_mask) | raw_req;
  end

  // Pending flags; a frozen clock enable holds them untouched
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pend_ff <= {`IVPM_NUM_SRC{1'b0}};
    end
    else if (clk_en_in)
    begin
      pend_ff <= nxt_pend;
    end
  end

  // One-cycle strobe telling the core the vector below is fresh
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      vec_valid_ff_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      vec_valid_ff_out <= ack_take;
    end
  end

  // Index and vector stand until the next accepted acknowledge, so a
  // slow core may read them late without a hold request
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      req_idx_ff_out <= 5'h00;
      vec_addr_ff_out <= 16'h0000;
    end
    else if (clk_en_in && ack_take)
    begin
      req_idx_ff_out <= pick_idx;
      vec_addr_ff_out <= pick_vec;
    end
  end

  // Request level and flags go out straight, so the core sees a new
  // source one cycle after it fires

  assign irq_req_out = pick_any;
  assign pending_out = pend_ff;

endmodule // ivpm_map

// ### rtl/ivpm_regs.vh
/*
  Constants of the vectored interrupt source map: source count, priority
  indices and vector table addresses.
  Assumes inclusion by bare name from the map's design files.
*/
`ifndef IVPM_REGS_VH
`define IVPM_REGS_VH

// Number of maskable request lines, indices 0 to 23
`define IVPM_NUM_SRC 24
`define IVPM_IDX_W 5
`define IVPM_VEC_W 16
// Sources counted including the software break, per package size
`define IVPM_SRC_SMALL 5'h18
`define IVPM_SRC_LARGE 5'h19
// Vector base: vector = base + 2 * index
`define IVPM_VEC_BASE 16'h0004
// Priority indices of the named sources
`define IVPM_PRI_LOW_VOLTAGE 5'h00
`define IVPM_PRI_PIN0 5'h01
`define IVPM_PRI_SERB_ERR 5'h07
`define IVPM_PRI_SERB_RX 5'h08
`define IVPM_PRI_SERB_TX 5'h09
`define IVPM_PRI_CSI_SERA_TX 5'h0A
`define IVPM_PRI_TIMER_H_ONE 5'h0B
`define IVPM_PRI_TIMER_H_ZERO 5'h0C
`define IVPM_PRI_EVA 5'h0D
`define IVPM_PRI_WIDE_A 5'h0E
`define IVPM_PRI_WIDE_B 5'h0F
`define IVPM_PRI_CONV 5'h10
`define IVPM_PRI_SERA_RX 5'h11
`define IVPM_PRI_WATCH_INT 5'h12
`define IVPM_PRI_EVB 5'h13
`define IVPM_PRI_KEY 5'h14
`define IVPM_PRI_WATCH_OVF 5'h15
`define IVPM_PRI_PIN6 5'h16
`define IVPM_PRI_TWO_WIRE 5'h17
// Vectors of pin 6 and two-wire, for reference; pin 6 holds base + 2 * index, 16'h0030, two-wire holds 16'h0034 where base + 2 * index gives 16'h0032
`define IVPM_VEC_PIN6 16'h0030
`define IVPM_VEC_TWO_WIRE 16'h0034

`endif

// ### rtl/ivpm_pick.v
/*
  Fixed-priority picker: lowest set index of a request vector, with its
  vector table address.
  Assumes a purely combinational use by the map top.
*/
`timescale 1ns/100ps
`include "ivpm_regs.vh"

module ivpm_pick #(
  parameter N = `IVPM_NUM_SRC
) (
  input wire [N-1:0] req_in,
  output reg any_out,
  output reg [`IVPM_IDX_W-1:0] idx_out,
  output wire [`IVPM_VEC_W-1:0] vec_out
);

  // Vector address from index, base plus twice the index
  function [`IVPM_VEC_W-1:0] ivpm_vec_of;
    input [`IVPM_IDX_W-1:0] idx;
    begin
      ivpm_vec_of = `IVPM_VEC_BASE + {10'h000, idx, 1'b0};
    end
  endfunction

  integer i;

  // Scan downwards so the lowest index wins last
  always @*
  begin
    any_out = 1'b0;
    idx_out = 5'h00;
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (req_in[i])
      begin
        any_out = 1'b1;
        idx_out = i[`IVPM_IDX_W-1:0];
      end
    end
  end

  assign vec_out = ivpm_vec_of(idx_out);

endmodule // ivpm_pick

// ### bench/ivpm_map_sva.sv
/* Port assertions for the source map.
   Assumes one clock domain; bound to every map instance. */
`timescale 1ns/100ps
module ivpm_map_sva #(
  parameter LARGE_PKG = 1'b1
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire clk_en_in,
  input wire ack_in,
  input wire low_voltage_irq_in,
  input wire irq_req_out,
  input wire [4:0] req_idx_ff_out,
  input wire [15:0] vec_addr_ff_out,
  input wire vec_valid_ff_out,
  input wire [4:0] src_count_out,
  input wire [23:0] pending_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // An accepted acknowledge
  wire take = clk_en_in && ack_in && irq_req_out;
  a_src_count: assert property (src_count_out == (LARGE_PKG ? 5'h19 : 5'h18))
    else $error("source count wrong");
  a_low_volt: assert property (clk_en_in && low_voltage_irq_in |=> pending_out[0])
    else $error("low voltage not pending");
  a_req_level: assert property (irq_req_out == (|pending_out))
    else $error("request level wrong");
  a_ack_valid: assert property (take |=> vec_valid_ff_out)
    else $error("no vector after ack");
  a_no_spurious: assert property (!take |=> !vec_valid_ff_out)
    else $error("vector without ack");
  // Lowest set bit of the old flags must be the one chosen
  a_lowest_win: assert property (take |=> (24'h000001 << req_idx_ff_out) ==
    ($past(pending_out) & (~$past(pending_out) + 24'h000001)))
    else $error("not lowest index");
  a_vec_form: assert property (vec_valid_ff_out |->
    vec_addr_ff_out == 16'h0004 + {10'h000, req_idx_ff_out, 1'b0})
    else $error("vector address wrong");
  a_vec_hold: assert property (!vec_valid_ff_out |-> $stable(vec_addr_ff_out))
    else $error("vector moved");
endmodule // ivpm_map_sva

bind ivpm_map ivpm_map_sva #(.LARGE_PKG(LARGE_PKG)) u_sva (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .ack_in(ack_in),
  .low_voltage_irq_in(low_voltage_irq_in), .irq_req_out(irq_req_out),
  .req_idx_ff_out(req_idx_ff_out), .vec_addr_ff_out(vec_addr_ff_out),
  .vec_valid_ff_out(vec_valid_ff_out), .src_count_out(src_count_out),
  .pending_out(pending_out));

// ### bench/ivpm_core_model.sv
/* Core model that acknowledges whatever the map offers.
   Assumes the map's clock; en_in low stalls it. */
`timescale 1ns/100ps
module ivpm_core_model (
  input wire clk_in,
  input wire rst_n_in,
  input wire en_in,
  input wire irq_req_in,
  output reg ack_out
);
  // Ack follows the request one edge late, as a slow core would
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      ack_out <= 1'b0;
    else
      ack_out <= en_in && irq_req_in;
endmodule // ivpm_core_model

// ### bench/test_interrupt_vector_priority_map.sv
/* Bench for the source map: count, single sources, burst.
   Assumes the default large package. */
`timescale 1ns/100ps
module test_interrupt_vector_priority_map;
  reg clk = 0, rst_n = 0, en = 1, ce = 1;
  reg [23:0] src = 0;
  reg [1:0] alt = 0;
  wire irq, ack, vld;
  wire [4:0] idx, cnt;
  wire [15:0] vec;
  integer err_count = 0, checked = 0, cyc = 0, i;
  ivpm_map dut_u (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(ce),
    .low_voltage_irq_in(src[0]), .pin_edge_irq_in({src[22], src[6:1]}),
    .serial_b_rx_error_irq_in(src[7]), .serial_b_rx_done_irq_in(src[8]),
    .serial_b_tx_done_irq_in(src[9]), .clocked_serial_done_irq_in(src[10]),
    .serial_a_tx_done_irq_in(alt[0]), .timer_h_one_match_irq_in(src[11]),
    .timer_h_zero_match_irq_in(src[12]), .event_counter_a_match_irq_in(src[13]),
    .wide_timer_chan_a_irq_in(src[14]), .wide_timer_chan_b_irq_in(src[15]),
    .conversion_done_irq_in(src[16]), .serial_a_rx_irq_in(src[17]),
    .watch_interval_irq_in(src[18]), .event_counter_b_match_irq_in(src[19]),
    .key_input_irq_in(src[20]), .watch_overflow_irq_in(src[21]),
    .two_wire_done_irq_in(src[23]), .muldiv_done_irq_in(alt[1]), .ack_in(ack),
    .irq_req_out(irq), .req_idx_ff_out(idx), .vec_addr_ff_out(vec),
    .vec_valid_ff_out(vld), .src_count_out(cnt), .pending_out());
  ivpm_core_model core_u (.clk_in(clk), .rst_n_in(rst_n), .en_in(en),
    .irq_req_in(irq), .ack_out(ack));
  // Free-running clock and hang guard
  initial forever #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      err_count = err_count + 1;
      results;
    end
  end
  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Pulse sources for one cycle, just after an edge
  task hit(input [23:0] s, input [1:0] a);
    begin
      @(posedge clk) #1 src = s;
      alt = a;
      @(posedge clk) #1 src = 0;
      alt = 0;
    end
  endtask
  // Wait a bounded time for the vector pulse, then judge it
  task take(input [4:0] k);
    integer n;
    begin
      n = 0;
      while (vld !== 1'b1 && n < 30)
      begin
        @(posedge clk) #1 n = n + 1;
      end
      chk("index", 16'(k), 16'(idx));
      chk("vector", 16'h0004 + 16'({k, 1'b0}), vec);
      @(posedge clk) #1;
    end
  endtask
  task t_count;
    begin
      chk("count", 16'h0019, 16'(cnt));
      $display("count test done");
    end
  endtask
  task t_single;
    begin
      for (i = 0; i < 24; i = i + 1)
      begin
        hit(24'h000001 << i, 2'h0);
        take(i[4:0]);
      end
      hit(24'h000000, 2'h1);
      take(5'h0A);
      hit(24'h000000, 2'h2);
      take(5'h17);
      $display("single source test done");
    end
  endtask
  // Core stalled while all sources fire, then acks back to back
  task t_burst;
    begin
      en = 0;
      hit(24'hFFFFFF, 2'h3);
      en = 1;
      for (i = 0; i < 24; i = i + 1)
        take(i[4:0]);
      chk("irq", 16'h0000, 16'(irq));
      $display("burst test done");
    end
  endtask
  // Clock enable low must swallow a source pulse entirely
  task t_freeze;
    begin
      ce = 0;
      hit(24'h000001, 2'h0);
      @(posedge clk) #1;
      chk("frozen irq", 16'h0000, 16'(irq));
      ce = 1;
      @(posedge clk) #1;
      chk("idle irq", 16'h0000, 16'(irq));
      $display("freeze test done");
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Reset for eight cycles, then the scenarios
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    t_count;
    t_single;
    t_burst;
    t_freeze;
    results;
  end
endmodule // test_interrupt_vector_priority_map
